// *** core/dgc_pkg.sv ***
// package of constants for the dma global control register block
package dgc_pkg;
	// word offsets of the control group; byte address is four times the index
	localparam logic [11:0] global_control_idx = 12'h000;
	localparam logic [11:0] emulation_debug_idx = 12'h001;
	localparam logic [11:0] module_identification_idx = 12'h002;
	localparam logic [11:0] priority_control_idx = 12'h004;
	localparam logic [11:0] priority_status_idx = 12'h006;
	localparam logic [13:0] global_control_addr = {global_control_idx, 2'b00};
	localparam logic [13:0] emulation_debug_addr = {emulation_debug_idx, 2'b00};
	localparam logic [13:0] module_identification_addr = {module_identification_idx, 2'b00};
	localparam logic [13:0] priority_control_addr = {priority_control_idx, 2'b00};
	localparam logic [13:0] priority_status_addr = {priority_status_idx, 2'b00};
	// field positions
	localparam int global_abort_reset_bit = 0;
	localparam int arbiter_restart_bit = 1;
	localparam int run_free_bit = 15;
	localparam int precedence_bit = 0;
	localparam int type_lsb = 8;
	localparam int revision_lsb = 0;
	// reset values
	localparam logic run_free_reset = 1'b0;
	localparam logic precedence_reset = 1'b0;
	// axi responses
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
	// channel count and abort pulse delay in cycles
	localparam int channel_count = 6;
	localparam int abort_delay_cycles = 1;
endpackage : dgc_pkg

// *** core/dgc_global_control.sv ***
// global control, debug and identification registers of the dma block
`timescale 1ns/100ps
`default_nettype none

module dgc_global_control #(
	parameter logic [7:0] module_type = 8'h5A, // arbitrary value
	parameter logic [7:0] silicon_revision = 8'hA5 // arbitrary value
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// axi4-lite slave
	input wire logic [13:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [13:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// channel engine side
	input wire logic burst_active,
	input wire logic interrupted_burst_pending,
	input wire logic access_in_progress,
	input wire logic [2:0] active_channel,
	input wire logic [2:0] shadow_channel,
	input wire logic emulation_halt,
	output logic arbiter_restart,
	output logic global_abort_reset,
	output logic dma_reset_n,
	output logic channel_freeze,
	output logic first_channel_precedence,
	output logic restart_pending
);

	typedef enum logic [2:0] {
		dgc_idle_type = 3'b001,
		dgc_wait_type = 3'b010,
		dgc_fire_type = 3'b100
	} dgc_restart_state_type;

	logic rst_meta, rst_sync;
	// two-stage release of the async reset
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	function automatic logic wr_bit(input logic [31:0] d, input logic [3:0] s, input int pos);
		wr_bit = d[pos] & s[pos / 8];
	endfunction

	// axi state
	logic aw_held, w_held, next_aw_held, next_w_held;
	logic [13:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	// control state
	logic run_free, next_run_free, precedence, next_precedence;
	logic abort_armed, next_abort_armed, abort_pulse, next_abort_pulse;
	logic restart_pulse, next_restart_pulse;
	logic freeze, next_freeze;
	dgc_restart_state_type rst_state, next_rst_state;
	logic do_write, wr_ok;

	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready = !w_held && !bvalid;
	assign s_axi_arready = !rvalid;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;
	assign arbiter_restart = restart_pulse;
	assign global_abort_reset = abort_pulse;
	// the dma side drops at once, even mid-access stalled on the external port
	assign dma_reset_n = rst_sync && !abort_pulse;
	assign channel_freeze = freeze;
	assign first_channel_precedence = precedence;
	assign restart_pending = (rst_state != dgc_idle_type);

	// write path: address and data taken in either order
	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		do_write = aw_held && w_held;
		wr_ok = (aw_addr == dgc_pkg::global_control_addr) || (aw_addr == dgc_pkg::emulation_debug_addr)
			|| (aw_addr == dgc_pkg::priority_control_addr) || (aw_addr == dgc_pkg::module_identification_addr)
			|| (aw_addr == dgc_pkg::priority_status_addr);
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = wr_ok ? dgc_pkg::resp_okay : dgc_pkg::resp_slverr;
		end else if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
	end

	// control registers and command pulses
	always_comb begin
		next_run_free = run_free;
		next_precedence = precedence;
		next_abort_armed = 1'b0;
		// pulse lands two cycles after the write, one after the bus response, giving the bus its response first
		next_abort_pulse = abort_armed;
		next_restart_pulse = 1'b0;
		next_rst_state = rst_state;
		if (do_write && aw_addr == dgc_pkg::global_control_addr) begin
			// zero writes do nothing; nothing is stored so reads return zero
			if (wr_bit(w_data, w_strb, dgc_pkg::global_abort_reset_bit)) begin
				next_abort_armed = 1'b1;
			end
			if (wr_bit(w_data, w_strb, dgc_pkg::arbiter_restart_bit)) begin
				next_rst_state = dgc_wait_type;
			end
		end
		if (do_write && aw_addr == dgc_pkg::emulation_debug_addr && w_strb[1]) begin
			next_run_free = w_data[dgc_pkg::run_free_bit];
		end
		if (do_write && aw_addr == dgc_pkg::priority_control_addr && w_strb[0]) begin
			next_precedence = w_data[dgc_pkg::precedence_bit];
		end
		// restart waits for the running burst and any burst channel one cut into
		case (rst_state)
			dgc_idle_type: begin
			end
			dgc_wait_type: begin
				if (!burst_active && !interrupted_burst_pending) begin
					next_rst_state = dgc_fire_type;
				end
			end
			dgc_fire_type: begin
				// engine restarts at first enabled channel, channel two first when channel one leads
				next_restart_pulse = 1'b1;
				// a restart written in this very cycle wins over the return to idle
				if (next_rst_state != dgc_wait_type) begin
					next_rst_state = dgc_idle_type;
				end
			end
			default: next_rst_state = dgc_idle_type;
		endcase
		// abort clears restart and debug state too
		if (abort_pulse) begin
			next_run_free = dgc_pkg::run_free_reset;
			next_precedence = dgc_pkg::precedence_reset;
			next_rst_state = dgc_idle_type;
			next_restart_pulse = 1'b0;
		end
	end

	// freeze after the current access unless running free
	always_comb begin
		next_freeze = 1'b0;
		if (emulation_halt && !run_free) begin
			next_freeze = freeze || !access_in_progress;
		end
		if (abort_pulse) begin
			next_freeze = 1'b0;
		end
	end

	// read path
	always_comb begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = dgc_pkg::resp_okay;
			next_rdata = 32'h0000_0000;
			case (s_axi_araddr)
				dgc_pkg::global_control_addr: next_rdata = 32'h0000_0000;
				dgc_pkg::emulation_debug_addr: next_rdata[dgc_pkg::run_free_bit] = run_free;
				dgc_pkg::module_identification_addr: begin
					next_rdata[dgc_pkg::type_lsb +: 8] = module_type;
					next_rdata[dgc_pkg::revision_lsb +: 8] = silicon_revision;
				end
				dgc_pkg::priority_control_addr: next_rdata[dgc_pkg::precedence_bit] = precedence;
				dgc_pkg::priority_status_addr: next_rdata[6:0] = {shadow_channel, 1'b0, active_channel};
				default: next_rresp = dgc_pkg::resp_slverr;
			endcase
		end else if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	// register stage
	always_ff @(posedge core_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			aw_held <= 1'b0;
			aw_addr <= 14'h0000;
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= 2'h0;
			run_free <= dgc_pkg::run_free_reset;
			precedence <= dgc_pkg::precedence_reset;
			abort_armed <= 1'b0;
			abort_pulse <= 1'b0;
			restart_pulse <= 1'b0;
			freeze <= 1'b0;
			rst_state <= dgc_idle_type;
		end else if (clk_en) begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			run_free <= next_run_free;
			precedence <= next_precedence;
			abort_armed <= next_abort_armed;
			abort_pulse <= next_abort_pulse;
			restart_pulse <= next_restart_pulse;
			freeze <= next_freeze;
			rst_state <= next_rst_state;
		end
	end

	sequence s_abort_write;
		do_write && aw_addr == dgc_pkg::global_control_addr && wr_bit(w_data, w_strb, dgc_pkg::global_abort_reset_bit);
	endsequence

	property p_abort_delay;
		@(posedge core_clk) disable iff (!rst_sync)
		(s_abort_write and clk_en) ##1 clk_en |=> abort_pulse && !dma_reset_n;
	endproperty
	a_abort_delay: assert property (p_abort_delay) else $error("abort pulse not two edges after write");

	property p_restart_waits;
		@(posedge core_clk) disable iff (!rst_sync)
		restart_pulse |-> $past(!burst_active && !interrupted_burst_pending, 2);
	endproperty
	a_restart_waits: assert property (p_restart_waits) else $error("restart fired during a burst");

	property p_restart_holds;
		@(posedge core_clk) disable iff (!rst_sync)
		(rst_state == dgc_wait_type && interrupted_burst_pending && !abort_pulse) |=> rst_state == dgc_wait_type;
	endproperty
	a_restart_holds: assert property (p_restart_holds) else $error("restart left wait early");

	property p_zero_read;
		@(posedge core_clk) disable iff (!rst_sync)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == dgc_pkg::global_control_addr && clk_en)
			|=> rvalid && rdata == 32'h0000_0000;
	endproperty
	a_zero_read: assert property (p_zero_read) else $error("control reads nonzero");

	property p_no_freeze_free;
		@(posedge core_clk) disable iff (!rst_sync)
		(run_free && clk_en) |=> !freeze;
	endproperty
	a_no_freeze_free: assert property (p_no_freeze_free) else $error("froze while running free");

	property p_freeze_after_access;
		@(posedge core_clk) disable iff (!rst_sync)
		$rose(freeze) |-> $past(!access_in_progress && emulation_halt && !run_free);
	endproperty
	a_freeze_after_access: assert property (p_freeze_after_access) else $error("froze mid access");

	property p_id_read;
		@(posedge core_clk) disable iff (!rst_sync)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == dgc_pkg::module_identification_addr && clk_en)
			|=> rdata[15:0] == {module_type, silicon_revision};
	endproperty
	a_id_read: assert property (p_id_read) else $error("identification mismatch");

	property p_abort_clears;
		@(posedge core_clk) disable iff (!rst_sync)
		(abort_pulse && clk_en) |=> !precedence && !run_free && !freeze && rst_state == dgc_idle_type;
	endproperty
	a_abort_clears: assert property (p_abort_clears) else $error("abort left state");

endmodule // dgc_global_control
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the dma global control registers
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam logic [7:0] mod_type = 8'h3C; // arbitrary value
	localparam logic [7:0] sil_rev = 8'hC3; // arbitrary value
	logic core_clk = 1'h0;
	logic nrst = 1'h0;
	logic ce = 1'h1;
	logic awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
	logic ba = 1'h0, ibp = 1'h0, aip = 1'h0, hlt = 1'h0;
	logic [13:0] awa = 14'h0, ara = 14'h0;
	logic [31:0] wd = 32'h0;
	logic [2:0] ac = 3'h0, sc = 3'h0;
	logic awr, wr_, bv, arr, rv, ars, gar, drn, cf, fcp, rp;
	logic [1:0] br, rr;
	logic [31:0] rd;
	logic [34:0] rq[$];
	logic [1:0] bq[$];
	int miscompares = 0, samples_checked = 0, ab_n = 0, rs_n = 0;
	integer seed = 32'h92FC47C8;
	logic [31:0] x;

	always #4 core_clk = ~core_clk;

	dgc_global_control #(.module_type(mod_type), .silicon_revision(sil_rev)) uut (
		.core_clk(core_clk), .nrst(nrst), .clk_en(ce),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
		.burst_active(ba), .interrupted_burst_pending(ibp), .access_in_progress(aip),
		.active_channel(ac), .shadow_channel(sc), .emulation_halt(hlt),
		.arbiter_restart(ars), .global_abort_reset(gar), .dma_reset_n(drn),
		.channel_freeze(cf), .first_channel_precedence(fcp), .restart_pending(rp)
	);

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// read note: top bit marks data as don't-care
	task automatic cmp_rd(input logic [34:0] e);
		cmp({30'h0, rr}, {30'h0, e[33:32]});
		if (!e[34]) cmp(rd, e[31:0]);
	endtask

	task automatic cmp_wr(input logic [1:0] e);
		cmp({30'h0, br}, {30'h0, e});
	endtask

	// response monitor; an answer with no note counts as a mismatch
	always @(posedge core_clk) begin
		if (rv && rre) begin
			if (rq.size() == 0) cmp(32'h1, 32'h0);
			else cmp_rd(rq.pop_front());
		end
		if (bv && bre) begin
			if (bq.size() == 0) cmp(32'h1, 32'h0);
			else cmp_wr(bq.pop_front());
		end
		if (ars) rs_n++;
		if (gar) begin
			ab_n++;
			cmp({31'h0, drn}, 32'h0);
		end
	end

	// both halves offered together, each dropped when taken
	task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ad, dd;
		ad = 1'h0;
		dd = 1'h0;
		bq.push_back(r);
		awa <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		bre <= 1'h1;
		while (!(ad && dd)) begin
			@(posedge core_clk);
			if (awr) ad = 1'h1;
			if (wr_) dd = 1'h1;
			if (ad) awv <= 1'h0;
			if (dd) wv <= 1'h0;
		end
		do @(posedge core_clk); while (!bv);
		bre <= 1'h0;
		@(posedge core_clk);
	endtask

	task automatic rd_(input logic [13:0] a, input logic [1:0] r, input logic [31:0] e, input logic dc);
		rq.push_back({dc, r, e});
		ara <= a;
		arv <= 1'h1;
		rre <= 1'h1;
		do @(posedge core_clk); while (!arr);
		arv <= 1'h0;
		do @(posedge core_clk); while (!rv);
		rre <= 1'h0;
		@(posedge core_clk);
	endtask

	task automatic summarize;
		if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// watchdog well beyond the hundred-odd cycles the sequence needs
	initial begin
		repeat (5000) @(posedge core_clk);
		miscompares++;
		summarize();
	end

	// main sequence
	initial begin
		repeat (6) @(posedge core_clk);
		nrst <= 1'h1;
		repeat (3) @(posedge core_clk);
		rd_(14'h0008, 2'h0, {16'h0, mod_type, sil_rev}, 1'h0);
		rd_(14'h0004, 2'h0, 32'h0, 1'h0);
		rd_(14'h0010, 2'h0, 32'h0, 1'h0);
		wr(14'h0008, 32'hFFFF, 2'h0);
		rd_(14'h0008, 2'h0, {16'h0, mod_type, sil_rev}, 1'h0);
		rd_(14'h000C, 2'h2, 32'h0, 1'h1);
		wr(14'h0014, 32'h1, 2'h2);
		// zero writes must not fire either command
		wr(14'h0000, 32'h0, 2'h0);
		repeat (4) @(posedge core_clk);
		cmp(ab_n + rs_n, 32'h0);
		// restart held off by a running burst, then by an interrupted one
		ba <= 1'h1;
		wr(14'h0000, 32'h2, 2'h0);
		rd_(14'h0000, 2'h0, 32'h0, 1'h0);
		repeat (8) @(posedge core_clk);
		cmp(rs_n, 32'h0);
		cmp({31'h0, rp}, 32'h1);
		ba <= 1'h0;
		ibp <= 1'h1;
		repeat (8) @(posedge core_clk);
		cmp(rs_n, 32'h0);
		ibp <= 1'h0;
		repeat (6) @(posedge core_clk);
		cmp(rs_n, 32'h1);
		cmp({31'h0, rp}, 32'h0);
		// random payloads: only the run-free and precedence bits may stick
		x = $random(seed);
		wr(14'h0004, {x[31:16], 1'h1, x[14:0]}, 2'h0);
		rd_(14'h0004, 2'h0, 32'h8000, 1'h0);
		x = $random(seed);
		wr(14'h0010, {x[31:1], 1'h1}, 2'h0);
		cmp({31'h0, fcp}, 32'h1);
		rd_(14'h0010, 2'h0, 32'h1, 1'h0);
		// priority changed with no burst running, so restart the arbiter before going on
		wr(14'h0000, 32'h2, 2'h0);
		repeat (4) @(posedge core_clk);
		cmp(rs_n, 32'h2);
		x = $random(seed);
		ac <= x[2:0];
		sc <= x[6:4];
		repeat (2) @(posedge core_clk);
		rd_(14'h0018, 2'h0, {25'h0, x[6:4], 1'h0, x[2:0]}, 1'h0);
		// abort clears the settings held above, with an access still hanging
		aip <= 1'h1;
		wr(14'h0000, 32'h1, 2'h0);
		repeat (4) @(posedge core_clk);
		cmp(ab_n, 32'h1);
		cmp({31'h0, fcp}, 32'h0);
		rd_(14'h0004, 2'h0, 32'h0, 1'h0);
		rd_(14'h0010, 2'h0, 32'h0, 1'h0);
		// halt waits for the access to end, then freezes
		hlt <= 1'h1;
		aip <= 1'h1;
		repeat (4) @(posedge core_clk);
		cmp({31'h0, cf}, 32'h0);
		aip <= 1'h0;
		repeat (3) @(posedge core_clk);
		cmp({31'h0, cf}, 32'h1);
		// clock enable low holds the frozen state although the halt ends
		ce <= 1'h0;
		hlt <= 1'h0;
		repeat (3) @(posedge core_clk);
		cmp({31'h0, cf}, 32'h1);
		ce <= 1'h1;
		repeat (3) @(posedge core_clk);
		cmp({31'h0, cf}, 32'h0);
		wr(14'h0004, 32'h8000, 2'h0);
		hlt <= 1'h1;
		repeat (4) @(posedge core_clk);
		cmp({31'h0, cf}, 32'h0);
		hlt <= 1'h0;
		repeat (2) @(posedge core_clk);
		summarize();
	end
endmodule // tb
`default_nettype wire
